// ### uart_integrity.sv
// Integrity checking and channel routing for the primary UART control channel.
// Assumes a UART framer in front that delivers commands and paired data/check bytes,
// and a register file behind that takes forwarded writes and supplies read bytes.
`timescale 1ns/10ps
`default_nettype none

// How it works
// - Received write bytes are CRC checked; mismatch drops the write, counts an error.
// - Returned read bytes are followed by the device CRC; host verifies it.
// - Both ends keep a message counter, advance per transaction; host sends it each transaction, device returns it on reads.
// - A transaction with a disagreeing counter is rejected and counted as error.
// - CRC and counter checks apply only to the primary control channel.
// - After power-on both integrity features stay off until software enables them.
// - Register local_remote_channel_disable bit 5 cuts primary pins, bit 4 blocks link A control.
// - Register passthrough_enable_and_linkb_disable bits 4 and 5 enable pass-through channels, bit 6 swaps pins.
// - Register passthrough_enable_and_linkb_disable bit 2 blocks link B control access, reset one.
// - Registers passthrough1_link_disable to passthrough2_linkb_and_uart_select hold per-link pass-through disables.
// - Register passthrough2_linkb_and_uart_select bit 4 selects UART when zero, loaded from boot pin.
// - Register integrity_feature_config bits 4:3 choose the counted channel, code three reserved.
// - Bit 2 enables message counting; bit 1 enables CRC only with bit 2.
// - Bit 0 is the override; while zero both features stay disabled.
// - Writing one to message_counter_clear bit 0 clears the message counter.
// - Register error_count_clear bit 0 clears CRC errors, bit 1 clears counter errors.
// - Message counter readable: low byte message_counter_low, high byte message_counter_high.
// - Error counts at crc_error_count and counter_error_count, last CRC value at crc_value_readback.
module uart_integrity #(
  parameter logic [7:0] CRC_POLY = uart_integrity_pkg::CRC_POLY_DEFAULT,
  parameter logic [7:0] CRC_INIT = uart_integrity_pkg::CRC_INIT_DEFAULT
) (
  input  wire logic                        CLK,
  input  wire logic                        RST_N,
  input  wire logic                        BOOT_CONFIG_PIN,
  input  wire uart_integrity_pkg::cmd_t    CMD,
  input  wire uart_integrity_pkg::wbyte_t  WR_BYTE,
  input  wire uart_integrity_pkg::byte_t   RD_BYTE,
  output var  uart_integrity_pkg::byte_t   TX,
  output var  logic                        TX_BUSY,
  output var  uart_integrity_pkg::regwr_t  REG_WR,
  output var  uart_integrity_pkg::route_t  ROUTE,
  output var  uart_integrity_pkg::status_t STATUS
);
  import uart_integrity_pkg::*;

  typedef enum logic [1:0] {TX_IDLE, TX_CNT_HI, TX_CRC} tx_state_t;

  // Register storage.
  logic [7:0]  chan_disable;
  logic [7:0]  pt_enable;
  logic [7:0]  pt1_link;
  logic [7:0]  pt2_linka;
  logic [7:0]  pt2_linkb;
  logic [7:0]  feature;
  logic [7:0]  crc_last;
  logic [15:0] msg_count;
  logic [7:0]  crc_errs;
  logic [7:0]  cnt_errs;
  logic        boot_done;

  // Transaction state.
  logic        txn_open;
  logic        txn_ok;
  logic        txn_write;
  logic [15:0] cur_addr;

  // Return path state.
  tx_state_t   tx_state;
  tx_state_t   next_tx_state;
  byte_t       next_tx;
  logic [7:0]  tx_crc_hold;
  logic [7:0]  cnt_hold_hi;
  logic [7:0]  cnt_hold_lo;
  logic        cnt_pend;
  logic        loc_pend;
  logic [7:0]  loc_data;
  logic        next_cnt_pend;
  logic        next_loc_pend;
  logic        take_cnt;
  logic        take_loc;
  logic        take_rd;

  // Decoded events.
  logic        crc_active;
  logic        seq_active;
  logic        seq_check;
  logic        cmd_primary;
  logic        cmd_reject;
  logic        cmd_accept;
  logic        byte_in;
  logic [7:0]  rx_crc;
  logic        crc_bad;
  logic        byte_accept;
  logic        is_local;
  logic        local_wr;
  logic        local_rd;
  logic        cnt_err_inc;
  logic        crc_err_inc;
  logic        clr_cnt_errs;
  logic        clr_crc_errs;
  logic        clr_count;

  // CRC of one byte from the initial value; the engine is the same in both directions.
  function automatic logic [7:0] crc_byte(input logic [7:0] data);
    logic [7:0] c;
    c = CRC_INIT ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : crc_byte

  // True for any offset that this block answers itself.
  function automatic logic local_addr(input logic [15:0] a);
    logic hit;
    hit = 1'b0;
    if (a == ADDR_CHAN_DISABLE || a == ADDR_PT_ENABLE || a == ADDR_PT1_LINK) begin
      hit = 1'b1;
    end else if (a == ADDR_PT2_LINKA || a == ADDR_PT2_LINKB || a == ADDR_FEATURE) begin
      hit = 1'b1;
    end else if (a >= ADDR_CNT_CLEAR && a <= ADDR_CNT_ERRS) begin
      hit = 1'b1;
    end
    return hit;
  endfunction : local_addr

  ////////////////////////////////////////////////////////////////////////////////////////
  // Feature decode and command handling.

  // The override bit gates both features, and CRC additionally needs counting on.
  assign seq_active  = feature[BIT_OVERRIDE] & feature[BIT_SEQ_EN];
  assign crc_active  = seq_active & feature[BIT_CRC_EN];
  // Only the primary channel carries register traffic, so only it is checked.
  assign cmd_primary = CMD.start && (CMD.channel == CH_PRIMARY);
  assign seq_check   = seq_active && (feature[FEAT_SEL_MSB:FEAT_SEL_LSB] == CH_PRIMARY);
  assign cmd_reject  = cmd_primary && seq_check && (CMD.count != msg_count);
  assign cmd_accept  = cmd_primary && !cmd_reject;
  assign cnt_err_inc = cmd_reject;

  // Write bytes are checked against the host's check byte before use.
  assign byte_in     = WR_BYTE.valid && txn_open && txn_write && txn_ok;
  assign rx_crc      = crc_byte(WR_BYTE.data);
  assign crc_bad     = crc_active && (rx_crc != WR_BYTE.check);
  assign crc_err_inc = byte_in && crc_bad;
  assign byte_accept = byte_in && !crc_bad;
  assign is_local    = local_addr(cur_addr);
  assign local_wr    = byte_accept && is_local;
  assign local_rd    = cmd_accept && !CMD.write && local_addr(CMD.addr);

  // Self-clearing command bits act only on an accepted write.
  assign clr_count    = local_wr && (cur_addr == ADDR_CNT_CLEAR) && WR_BYTE.data[BIT_CNT_CLEAR];
  assign clr_crc_errs = local_wr && (cur_addr == ADDR_ERR_CLEAR) && WR_BYTE.data[BIT_CLR_CRC_ERRS];
  assign clr_cnt_errs = local_wr && (cur_addr == ADDR_ERR_CLEAR) && WR_BYTE.data[BIT_CLR_CNT_ERRS];

  // Transaction tracking; a failed byte poisons the rest of that write.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      txn_open  <= 1'b0;
      txn_ok    <= 1'b0;
      txn_write <= 1'b0;
      cur_addr  <= RST_COUNT;
    end else if (CMD.start) begin
      txn_open  <= cmd_primary;
      txn_ok    <= cmd_accept;
      txn_write <= CMD.write;
      cur_addr  <= CMD.addr;
    end else if (byte_in) begin
      txn_ok    <= !crc_bad;
      cur_addr  <= cur_addr + 16'h0001;
    end
  end

  // Accepted writes to addresses outside this block go on to the register file.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      REG_WR <= '0;
    end else begin
      REG_WR.strobe <= byte_accept && !is_local;
      REG_WR.addr   <= cur_addr;
      REG_WR.data   <= WR_BYTE.data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  // Configuration registers.

  // Routing and feature registers; writes land only after the integrity checks pass.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      chan_disable <= RST_CHAN_DISABLE;
      pt_enable    <= RST_PT_ENABLE;
      pt1_link     <= RST_PT1_LINK;
      pt2_linka    <= RST_PT2_LINKA;
      feature      <= RST_FEATURE;
    end else if (local_wr) begin
      if (cur_addr == ADDR_CHAN_DISABLE) begin
        chan_disable <= WR_BYTE.data;
      end else if (cur_addr == ADDR_PT_ENABLE) begin
        pt_enable <= WR_BYTE.data;
      end else if (cur_addr == ADDR_PT1_LINK) begin
        pt1_link <= WR_BYTE.data;
      end else if (cur_addr == ADDR_PT2_LINKA) begin
        pt2_linka <= WR_BYTE.data;
      end else if (cur_addr == ADDR_FEATURE) begin
        feature <= WR_BYTE.data;
      end
    end
  end

  // The mode bit follows the strap once, on the first edge after reset release.
  // Software may still overwrite it, though doing so is discouraged.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pt2_linkb <= RST_PT2_LINKB;
      boot_done <= 1'b0;
    end else if (!boot_done) begin
      pt2_linkb[BIT_UART_SELECT] <= BOOT_CONFIG_PIN;
      boot_done                  <= 1'b1;
    end else if (local_wr && cur_addr == ADDR_PT2_LINKB) begin
      pt2_linkb <= WR_BYTE.data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  // Counters.

  // The counter advances once per accepted primary transaction while counting is on and selects the primary channel.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      msg_count <= RST_COUNT;
    end else if (cmd_accept && seq_check) begin
      msg_count <= msg_count + 16'h0001;
    end else if (clr_count) begin
      msg_count <= RST_COUNT;
    end
  end

  // Error counts stick at full scale; an error in the clearing cycle is kept as one.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      crc_errs <= RST_BYTE;
    end else if (crc_err_inc) begin
      if (clr_crc_errs) begin
        crc_errs <= ERR_COUNT_ONE;
      end else if (crc_errs != ERR_COUNT_MAX) begin
        crc_errs <= crc_errs + ERR_COUNT_ONE;
      end
    end else if (clr_crc_errs) begin
      crc_errs <= RST_BYTE;
    end
  end

  // Same policy for the message counter error count.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_errs <= RST_BYTE;
    end else if (cnt_err_inc) begin
      if (clr_cnt_errs) begin
        cnt_errs <= ERR_COUNT_ONE;
      end else if (cnt_errs != ERR_COUNT_MAX) begin
        cnt_errs <= cnt_errs + ERR_COUNT_ONE;
      end
    end else if (clr_cnt_errs) begin
      cnt_errs <= RST_BYTE;
    end
  end

  // Last CRC computed in either direction, for software inspection.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      crc_last <= RST_BYTE;
    end else if (byte_in && crc_active) begin
      crc_last <= rx_crc;
    end else if (next_tx_state == TX_CRC && tx_state != TX_CRC) begin
      crc_last <= crc_byte(next_tx.data);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  // Return path: counter bytes, read data, and the CRC after each data byte.

  // Pending local answers are captured at the command so the data is a snapshot.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_pend    <= 1'b0;
      loc_pend    <= 1'b0;
      loc_data    <= RST_BYTE;
      cnt_hold_lo <= RST_BYTE;
      cnt_hold_hi <= RST_BYTE;
    end else begin
      cnt_pend <= next_cnt_pend;
      loc_pend <= next_loc_pend;
      if (cmd_accept && !CMD.write && seq_check) begin
        cnt_hold_lo <= msg_count[7:0];
        cnt_hold_hi <= msg_count[15:8];
      end
      if (local_rd) begin
        if (CMD.addr == ADDR_CHAN_DISABLE) begin
          loc_data <= chan_disable;
        end else if (CMD.addr == ADDR_PT_ENABLE) begin
          loc_data <= pt_enable;
        end else if (CMD.addr == ADDR_PT1_LINK) begin
          loc_data <= pt1_link;
        end else if (CMD.addr == ADDR_PT2_LINKA) begin
          loc_data <= pt2_linka;
        end else if (CMD.addr == ADDR_PT2_LINKB) begin
          loc_data <= pt2_linkb;
        end else if (CMD.addr == ADDR_FEATURE) begin
          loc_data <= feature;
        end else if (CMD.addr == ADDR_CRC_VALUE) begin
          loc_data <= crc_last;
        end else if (CMD.addr == ADDR_CNT_LOW) begin
          loc_data <= msg_count[7:0];
        end else if (CMD.addr == ADDR_CNT_HIGH) begin
          loc_data <= msg_count[15:8];
        end else if (CMD.addr == ADDR_CRC_ERRS) begin
          loc_data <= crc_errs;
        end else if (CMD.addr == ADDR_CNT_ERRS) begin
          loc_data <= cnt_errs;
        end else begin
          loc_data <= RST_BYTE;
        end
      end
    end
  end

  // Byte sequencer; the counter goes first, then data, each data byte trailed by CRC.
  always_comb begin
    next_tx_state = tx_state;
    next_tx       = '0;
    take_cnt      = 1'b0;
    take_loc      = 1'b0;
    take_rd       = 1'b0;
    case (tx_state)
      TX_IDLE: begin
        if (cnt_pend) begin
          take_cnt      = 1'b1;
          next_tx.valid = 1'b1;
          next_tx.data  = cnt_hold_lo;
          next_tx_state = TX_CNT_HI;
        end else if (loc_pend || RD_BYTE.valid) begin
          take_loc      = loc_pend;
          take_rd       = !loc_pend;
          next_tx.valid = 1'b1;
          next_tx.data  = loc_pend ? loc_data : RD_BYTE.data;
          next_tx_state = crc_active ? TX_CRC : TX_IDLE;
        end
      end
      TX_CNT_HI: begin
        next_tx.valid = 1'b1;
        next_tx.data  = cnt_hold_hi;
        next_tx_state = TX_IDLE;
      end
      TX_CRC: begin
        next_tx.valid = 1'b1;
        next_tx.data  = tx_crc_hold;
        next_tx_state = TX_IDLE;
      end
      default: begin
        next_tx_state = TX_IDLE;
      end
    endcase
    next_cnt_pend = (cnt_pend && !take_cnt) || (cmd_accept && !CMD.write && seq_check);
    next_loc_pend = (loc_pend && !take_loc) || local_rd;
  end

  // Sequencer registers; busy tells the read source to hold off.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      tx_state    <= TX_IDLE;
      TX          <= '0;
      TX_BUSY     <= 1'b0;
      tx_crc_hold <= RST_BYTE;
    end else begin
      tx_state <= next_tx_state;
      TX       <= next_tx;
      TX_BUSY  <= (next_tx_state != TX_IDLE) || next_cnt_pend || next_loc_pend;
      if (take_loc || take_rd) begin
        tx_crc_hold <= crc_byte(next_tx.data);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  // Registered routing and status outputs.

  // Disable bits are inverted into positive enables for the pin and link muxes.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ROUTE  <= '0;
      STATUS <= '0;
    end else begin
      ROUTE.primary_pins_en <= !chan_disable[BIT_DIS_PRIMARY_PINS];
      ROUTE.linka_cc_en     <= !chan_disable[BIT_DIS_LINKA_CC];
      ROUTE.linkb_cc_en     <= !pt_enable[BIT_DIS_LINKB_CC];
      ROUTE.pass1_en        <= pt_enable[BIT_PT1_EN];
      ROUTE.pass2_en        <= pt_enable[BIT_PT2_EN];
      ROUTE.pass_swap       <= pt_enable[BIT_PT_SWAP];
      ROUTE.pass1_linka_en  <= !pt1_link[BIT_PT1_DIS_LINKA];
      ROUTE.pass1_linkb_en  <= !pt1_link[BIT_PT1_DIS_LINKB];
      ROUTE.pass2_linka_en  <= !pt2_linka[BIT_PT2_DIS_LINKA];
      ROUTE.pass2_linkb_en  <= !pt2_linkb[BIT_PT2_DIS_LINKB];
      ROUTE.uart_mode       <= !pt2_linkb[BIT_UART_SELECT];
      STATUS.crc_active     <= crc_active;
      STATUS.seq_active     <= seq_active;
      STATUS.rejected       <= cmd_reject;
    end
  end

endmodule : uart_integrity

`default_nettype wire

// ### uart_integrity_pkg.sv
// Constants and carrier types for the primary control-channel integrity block.
// Assumes one core clock domain; every user of these names imports the whole package.
package uart_integrity_pkg;

  // Register offsets, as seen on the 16-bit register address of a command.
  localparam logic [15:0] ADDR_CHAN_DISABLE = 16'h0001;
  localparam logic [15:0] ADDR_PT_ENABLE    = 16'h0003;
  localparam logic [15:0] ADDR_PT1_LINK     = 16'h0004;
  localparam logic [15:0] ADDR_PT2_LINKA    = 16'h0005;
  localparam logic [15:0] ADDR_PT2_LINKB    = 16'h0006;
  localparam logic [15:0] ADDR_CNT_CLEAR    = 16'h3008;
  localparam logic [15:0] ADDR_ERR_CLEAR    = 16'h3009;
  localparam logic [15:0] ADDR_CRC_VALUE    = 16'h300a;
  localparam logic [15:0] ADDR_CNT_LOW      = 16'h300b;
  localparam logic [15:0] ADDR_CNT_HIGH     = 16'h300c;
  localparam logic [15:0] ADDR_CRC_ERRS     = 16'h300d;
  localparam logic [15:0] ADDR_CNT_ERRS     = 16'h300e;
  localparam logic [15:0] ADDR_FEATURE      = 16'h300f;

  // Reset values of the storing registers.
  localparam logic [7:0] RST_CHAN_DISABLE = 8'h00;
  localparam logic [7:0] RST_PT_ENABLE    = 8'h05;
  localparam logic [7:0] RST_PT1_LINK     = 8'h00;
  localparam logic [7:0] RST_PT2_LINKA    = 8'h00;
  localparam logic [7:0] RST_PT2_LINKB    = 8'h00;
  localparam logic [7:0] RST_FEATURE      = 8'h06;
  localparam logic [7:0] RST_BYTE         = 8'h00;
  localparam logic [15:0] RST_COUNT       = 16'h0000;

  // Field positions.
  localparam int BIT_DIS_PRIMARY_PINS = 5;
  localparam int BIT_DIS_LINKA_CC     = 4;
  localparam int BIT_PT_SWAP          = 6;
  localparam int BIT_PT2_EN           = 5;
  localparam int BIT_PT1_EN           = 4;
  localparam int BIT_DIS_LINKB_CC     = 2;
  localparam int BIT_PT1_DIS_LINKB    = 5;
  localparam int BIT_PT1_DIS_LINKA    = 4;
  localparam int BIT_PT2_DIS_LINKA    = 4;
  localparam int BIT_PT2_DIS_LINKB    = 5;
  localparam int BIT_UART_SELECT      = 4;
  localparam int FEAT_SEL_MSB         = 4;
  localparam int FEAT_SEL_LSB         = 3;
  localparam int BIT_SEQ_EN           = 2;
  localparam int BIT_CRC_EN           = 1;
  localparam int BIT_OVERRIDE         = 0;
  localparam int BIT_CNT_CLEAR        = 0;
  localparam int BIT_CLR_CNT_ERRS     = 1;
  localparam int BIT_CLR_CRC_ERRS     = 0;

  // Defaults for the CRC engine shared with the host model, and the error count constants.
  localparam logic [7:0] CRC_POLY_DEFAULT = 8'h07;
  localparam logic [7:0] CRC_INIT_DEFAULT = 8'h00;
  localparam logic [7:0] ERR_COUNT_MAX    = 8'hff;
  localparam logic [7:0] ERR_COUNT_ONE    = 8'h01;

  // Channel codes of the message counting select field.
  typedef enum logic [1:0] {
    CH_PRIMARY = 2'b00,
    CH_PASS1   = 2'b01,
    CH_PASS2   = 2'b10,
    CH_RSVD    = 2'b11
  } channel_t;

  // Start of one transaction, as framed by the UART controller.
  typedef struct packed {
    logic        start;
    logic        write;
    channel_t    channel;
    logic [15:0] addr;
    logic [15:0] count;
  } cmd_t;

  // A received write data byte with the check byte that followed it.
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic [7:0] check;
  } wbyte_t;

  // One byte with its valid strobe.
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } byte_t;

  // Accepted write forwarded to the register file.
  typedef struct packed {
    logic        strobe;
    logic [15:0] addr;
    logic [7:0]  data;
  } regwr_t;

  // Channel routing enables.
  typedef struct packed {
    logic primary_pins_en;
    logic linka_cc_en;
    logic linkb_cc_en;
    logic pass1_en;
    logic pass2_en;
    logic pass_swap;
    logic pass1_linka_en;
    logic pass1_linkb_en;
    logic pass2_linka_en;
    logic pass2_linkb_en;
    logic uart_mode;
  } route_t;

  // Integrity status.
  typedef struct packed {
    logic crc_active;
    logic seq_active;
    logic rejected;
  } status_t;

endpackage : uart_integrity_pkg

// ### uart_integrity_chk.sv
// Concurrent checks on the ports of the control-channel integrity block.
// Assumes one clock domain and the reset values from the shared package.
`timescale 1ns/10ps
`default_nettype none
module uart_integrity_chk (
  input wire logic                        CLK,
  input wire logic                        RST_N,
  input wire logic                        BOOT_CONFIG_PIN,
  input wire uart_integrity_pkg::cmd_t    CMD,
  input wire uart_integrity_pkg::wbyte_t  WR_BYTE,
  input wire uart_integrity_pkg::byte_t   RD_BYTE,
  input wire uart_integrity_pkg::byte_t   TX,
  input wire logic                        TX_BUSY,
  input wire uart_integrity_pkg::regwr_t  REG_WR,
  input wire uart_integrity_pkg::route_t  ROUTE,
  input wire uart_integrity_pkg::status_t STATUS
);
  import uart_integrity_pkg::*;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // A returned byte is the one the register file handed over a cycle before.
  sequence s_echo;
    TX.valid && TX.data == $past(RD_BYTE.data);
  endsequence
  a_wr_cause: assert property (REG_WR.strobe |-> $past(WR_BYTE.valid)
    && REG_WR.data == $past(WR_BYTE.data)) else $error("Forwarded write has no source.");
  a_rej_cause: assert property (STATUS.rejected |-> $past(CMD.start)
    && $past(STATUS.seq_active)) else $error("Reject without counted command.");
  a_rej_drop: assert property (STATUS.rejected && WR_BYTE.valid |=> !REG_WR.strobe)
    else $error("Rejected write was forwarded.");
  a_reset_off: assert property (!$past(RST_N) |-> STATUS == 3'b000)
    else $error("Integrity active after reset.");
  a_route_src: assert property ($changed(ROUTE.primary_pins_en) |-> !$past(RST_N, 2)
    || $past(WR_BYTE.valid, 2)) else $error("Routing changed with no write.");
  a_strap_load: assert property ($past(RST_N, 2) && !$past(RST_N, 3)
    |-> ROUTE.uart_mode == !$past(BOOT_CONFIG_PIN, 2)) else $error("Strap not loaded.");
  a_crc_needs: assert property (STATUS.crc_active |-> STATUS.seq_active)
    else $error("CRC active without counting.");
  a_echo_crc: assert property (RD_BYTE.valid && !TX_BUSY && !TX.valid
    |=> s_echo ##1 (TX.valid || !STATUS.crc_active)) else $error("Read byte lost.");
endmodule : uart_integrity_chk
////////////////////////////////////////////////////////////////////////////////
bind uart_integrity uart_integrity_chk u_chk (.CLK, .RST_N, .BOOT_CONFIG_PIN, .CMD,
  .WR_BYTE, .RD_BYTE, .TX, .TX_BUSY, .REG_WR, .ROUTE, .STATUS);
`default_nettype wire

// ### uart_host.sv
// Host controller model that frames commands and adds a check byte to data.
// Assumes the bench calls its tasks and the block keeps the package CRC defaults.
`timescale 1ns/10ps
`default_nettype none
module uart_host (
  input wire logic                       CLK,
  output var uart_integrity_pkg::cmd_t   CMD,
  output var uart_integrity_pkg::wbyte_t WR_BYTE
);
  import uart_integrity_pkg::*;
  initial CMD = '0;
  initial WR_BYTE = '0;
  // Byte CRC, MSB first, restarted for every byte as the device does.
  function automatic logic [7:0] crc8(input logic [7:0] d);
    crc8 = CRC_INIT_DEFAULT ^ d;
    for (int i = 0; i < 8; i++)
      crc8 = (crc8 << 1) ^ (crc8[7] ? CRC_POLY_DEFAULT : 8'h00);
  endfunction : crc8
  // One transaction; the data line is inverted once released so stale data never matches.
  task automatic send(input logic w, input logic [15:0] a, n, input logic [7:0] d, input logic b);
    @(negedge CLK) CMD = '{1'b1, w, CH_PRIMARY, a, n};
    @(negedge CLK) CMD.start = 1'b0;
    WR_BYTE = '{w, d, crc8(d) ^ {7'h00, b}};
    @(negedge CLK) WR_BYTE = '{1'b0, ~d, 8'h00};
    if (w && a < 16'h0007)
      repeat (100) @(negedge CLK);
  endtask : send
endmodule : uart_host
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the control-channel integrity block.
// Assumes the host model frames commands; the bench plays the register file.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import uart_integrity_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        boot_pin = 1'b1;
  byte_t       rd = '0;
  cmd_t        cmd;
  wbyte_t      wb;
  byte_t       tx;
  logic        busy;
  regwr_t      reg_wr;
  route_t      route;
  status_t     status;
  logic [7:0]  txq[$];
  logic [23:0] wrq[$];
  logic [7:0]  r;
  integer      seed = 32'h8d9ee526;
  int          err_count = 0;
  int          checks_done = 0;
  always #50 clk = ~clk;
  uart_integrity u_dut (.CLK(clk), .RST_N(rst_n), .BOOT_CONFIG_PIN(boot_pin), .CMD(cmd),
    .WR_BYTE(wb), .RD_BYTE(rd), .TX(tx), .TX_BUSY(busy), .REG_WR(reg_wr),
    .ROUTE(route), .STATUS(status));
  uart_host u_host (.CLK(clk), .CMD(cmd), .WR_BYTE(wb));
  task automatic check(input string s, input logic [23:0] e, g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask : check
  task automatic finish_test();
    check("pending", 24'h000000, 24'(txq.size() + wrq.size()));
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test
  // Each emitted result is matched against the oldest expectation.
  always @(negedge clk) begin
    if (tx.valid === 1'b1)
      check("tx", {16'h0000, txq.size() ? txq.pop_front() : 8'hxx}, {16'h0000, tx.data});
    if (reg_wr.strobe === 1'b1)
      check("reg_wr", wrq.size() ? wrq.pop_front() : 24'hxxxxxx, {reg_wr.addr, reg_wr.data});
  end
  // A bounded wait keeps a stuck sequencer from hanging the run.
  task automatic idle();
    for (int k = 0; k < 20 && busy !== 1'b0; k++)
      @(negedge clk);
    @(negedge clk);
  endtask : idle
  task automatic rdl(input logic [15:0] a, n, input logic [7:0] d, input logic seq, crc);
    if (seq)
      txq = {txq, n[7:0], n[15:8]};
    txq.push_back(d);
    if (crc)
      txq.push_back(u_host.crc8(d));
    u_host.send(1'b0, a, n, 8'h00, 1'b0);
    idle();
  endtask : rdl
  task automatic wr(input logic [15:0] a, n, input logic [7:0] d, input logic bad, fwd);
    if (fwd)
      wrq.push_back({a, d});
    u_host.send(1'b1, a, n, d, bad);
  endtask : wr
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    check("route", {13'h0000, route}, 24'h00061e);
    check("status", {21'h000000, status}, 24'h000000);
    rdl(ADDR_FEATURE, 16'h0000, RST_FEATURE, 1'b0, 1'b0);
    wr(ADDR_CHAN_DISABLE, 16'h0000, 8'h30, 1'b0, 1'b0);
    wr(ADDR_PT_ENABLE, 16'h0000, 8'h70, 1'b0, 1'b0);
    wr(ADDR_PT1_LINK, 16'h0000, 8'h30, 1'b0, 1'b0);
    wr(ADDR_PT2_LINKA, 16'h0000, 8'h10, 1'b0, 1'b0);
    wr(ADDR_PT2_LINKB, 16'h0000, 8'h20, 1'b0, 1'b0);
    check("route", {13'h0000, route}, 24'h0001e1);
    wr(ADDR_FEATURE, 16'h0000, 8'h0f, 1'b0, 1'b0);
    r = 8'($random(seed));
    wr(16'h0100, 16'h0000, r, 1'b0, 1'b1);
    wr(16'h0101, 16'h0000, ~r, 1'b1, 1'b0);
    check("status", {21'h000000, status}, 24'h000006);
    rdl(ADDR_CRC_ERRS, 16'h0000, 8'h01, 1'b0, 1'b1);
    rd = '{1'b1, r};
    txq = {txq, r, u_host.crc8(r)};
    @(negedge clk) rd = '{1'b0, ~r};
    idle();
    wr(ADDR_CNT_CLEAR, 16'h0000, 8'h01, 1'b0, 1'b0);
    wr(ADDR_FEATURE, 16'h0000, 8'h07, 1'b0, 1'b0);
    rdl(ADDR_CNT_ERRS, 16'h0000, 8'h00, 1'b1, 1'b1);
    wr(16'h0102, 16'h0005, r, 1'b0, 1'b0);
    rdl(ADDR_CNT_ERRS, 16'h0001, 8'h01, 1'b1, 1'b1);
    wr(ADDR_ERR_CLEAR, 16'h0002, 8'h03, 1'b0, 1'b0);
    rdl(ADDR_CRC_ERRS, 16'h0003, 8'h00, 1'b1, 1'b1);
    rdl(ADDR_CNT_LOW, 16'h0004, 8'h04, 1'b1, 1'b1);
    rdl(ADDR_CRC_VALUE, 16'h0005, u_host.crc8(8'h04), 1'b1, 1'b1);
    wr(ADDR_CNT_CLEAR, 16'h0006, 8'h01, 1'b0, 1'b0);
    rdl(ADDR_CNT_HIGH, 16'h0000, 8'h00, 1'b1, 1'b1);
    rdl(ADDR_CNT_ERRS, 16'h0001, 8'h00, 1'b1, 1'b1);
    finish_test();
  end
  // The whole sequence needs under two thousand cycles.
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    finish_test();
  end
endmodule : testbench
`default_nettype wire
